// File: design/ect_pkg.sv
// constants shared by the event counter timers
// assumes a 40 MHz system clock and a 32-bit classic wishbone register bus
package ect_pkg;
  localparam int unsigned CNT_W = 16;

  // register byte addresses
  localparam logic [7:0] ADR_QUAD_CNT   = 8'h00;
  localparam logic [7:0] ADR_QUAD_CTRL  = 8'h04;
  localparam logic [7:0] ADR_DOWN_CNT   = 8'h08;
  localparam logic [7:0] ADR_DOWN_CTRL  = 8'h0c;
  localparam logic [7:0] ADR_QUAD_RELD  = 8'h10;
  localparam logic [7:0] ADR_DOWN_RELD  = 8'h14;
  localparam int unsigned ADR_W = 8;

  // quadrature control fields
  localparam int unsigned QC_START_BIT = 0;
  localparam int unsigned QC_X4_BIT    = 1;
  localparam int unsigned QC_FREE_BIT  = 2;
  localparam int unsigned QC_W         = 3;

  // down counter control fields
  localparam int unsigned DC_START_BIT = 0;
  localparam int unsigned DC_EDGE_LSB  = 1;
  localparam int unsigned DC_W         = 3;

  localparam logic [CNT_W-1:0] CNT_MAX   = 16'hffff;
  localparam logic [CNT_W-1:0] CNT_ZERO  = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE   = 16'h0001;
  localparam logic [CNT_W-1:0] RST_CNT   = 16'h0000;
  localparam logic [QC_W-1:0]  RST_QCTRL = 3'h0;
  localparam logic [DC_W-1:0]  RST_DCTRL = 3'h0;

  typedef enum logic [1:0]
  {
    ECT_EDGE_FALL = 2'b00,
    ECT_EDGE_RISE = 2'b01,
    ECT_EDGE_BOTH = 2'b10,
    ECT_EDGE_NONE = 2'b11
  } ect_edge_t;
endpackage

// File: design/ect_edge_if.sv
// edge and level information passed from the pin synchroniser to the counters
// assumes both ends run on the same system clock
`timescale 1ns/100ps
interface ect_edge_if;
  logic a_lvl;
  logic b_lvl;
  logic a_rise;
  logic a_fall;
  logic b_rise;
  logic b_fall;
  logic d_rise;
  logic d_fall;

  modport src (output a_lvl, b_lvl, a_rise, a_fall, b_rise, b_fall, d_rise, d_fall);
  modport snk (input  a_lvl, b_lvl, a_rise, a_fall, b_rise, b_fall, d_rise, d_fall);
endinterface

// File: design/ect_pin_sync.sv
// pin synchroniser and edge detector for the three counter input pins
// assumes pins are asynchronous to clk_i; edges appear two cycles after the pin moves
`timescale 1ns/100ps
module ect_pin_sync
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic quad_primary_input_i,
  input  wire logic quad_secondary_input_i,
  input  wire logic down_event_input_i,
  ect_edge_if.src   edg
);
  logic [2:0] meta;
  logic [2:0] sync;
  logic [2:0] prev;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta <= 3'h0;
      sync <= 3'h0;
      prev <= 3'h0;
    end
    else
    begin
      meta <= {down_event_input_i, quad_secondary_input_i, quad_primary_input_i};
      sync <= meta;
      prev <= sync;
    end
  end

  assign edg.a_lvl  = sync[0];
  assign edg.b_lvl  = sync[1];
  assign edg.a_rise = sync[0] & ~prev[0];
  assign edg.a_fall = ~sync[0] & prev[0];
  assign edg.b_rise = sync[1] & ~prev[1];
  assign edg.b_fall = ~sync[1] & prev[1];
  assign edg.d_rise = sync[2] & ~prev[2];
  assign edg.d_fall = ~sync[2] & prev[2];
endmodule

// File: design/ect_timers.sv
// event counter timers: quadrature up/down counter and down-only event counter
// assumes a classic wishbone master on clk_i and asynchronous pulse pins
//
// Summary of operation
// RULE_01: reading the quadrature count register returns the live count.
// RULE_02: write while quadrature stopped loads reload register and counter.
// RULE_03: write while quadrature runs loads reload only; counter takes it at reload.
// RULE_04: normal mode: secondary high, primary rise counts up, primary fall down.
// RULE_05: x4 mode: primary rising while secondary high, all edges count up.
// RULE_06: x4 mode: primary falling while secondary high, all edges count down.
// RULE_07: down counter counts event pin edges: rising, falling or both.
// RULE_08: down counter only decrements; on underflow reloads and keeps counting.
// RULE_09: setting n gives one underflow per n+1 counted events.
// RULE_10: down counter runs while its start flag is 1, halts at 0.
// RULE_11: down counter pulses its interrupt request on underflow.
// RULE_12: reading the down count register returns the live count.
// RULE_13: write while down counter stopped loads reload register and counter.
// RULE_14: write while down counter runs loads reload only, used at underflow.
// RULE_15: quadrature overflow or underflow reloads the reload value.
// RULE_16: quadrature counter pulses its interrupt request on overflow or underflow.
// RULE_17: count type select picks reload type or free-running wrap.
// RULE_18: counters and reloads are 16 bits, pin edges found on the system clock.
// RULE_19: software sets the mode before setting the start flag.
`timescale 1ns/100ps
module ect_timers
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        quad_primary_input_i,
  input  wire logic        quad_secondary_input_i,
  input  wire logic        down_event_input_i,
  output logic             quad_irq_o,
  output logic             down_irq_o
);
  localparam int unsigned W = ect_pkg::CNT_W;

  ect_edge_if edg ();

  ect_pin_sync u_sync
  (
    .clk_i                  (clk_i),
    .rst_i                  (rst_i),
    .quad_primary_input_i   (quad_primary_input_i),
    .quad_secondary_input_i (quad_secondary_input_i),
    .down_event_input_i     (down_event_input_i),
    .edg                    (edg.src)
  ); // RULE_18

  logic [W-1:0]              quad_cnt;
  logic [W-1:0]              quad_reld;
  logic [W-1:0]              down_cnt;
  logic [W-1:0]              down_reld;
  logic [ect_pkg::QC_W-1:0]  quad_ctrl;
  logic [ect_pkg::DC_W-1:0]  down_ctrl;
  logic                      wr_req;
  logic                      quad_cnt_wr;
  logic                      down_cnt_wr;
  logic [W-1:0]              wr_val;
  logic                      quad_run;
  logic                      quad_x4;
  logic                      count_type_select;
  logic                      down_run;
  ect_pkg::ect_edge_t        down_edge;
  logic                      q_up;
  logic                      q_dn;
  logic                      q_ovf;
  logic                      q_unf;
  logic                      d_evt;
  logic                      d_unf;
  logic [31:0]               next_dat;

  assign quad_run          = quad_ctrl[ect_pkg::QC_START_BIT];
  assign quad_x4           = quad_ctrl[ect_pkg::QC_X4_BIT];
  assign count_type_select = quad_ctrl[ect_pkg::QC_FREE_BIT];
  assign down_run          = down_ctrl[ect_pkg::DC_START_BIT];
  assign down_edge         = ect_pkg::ect_edge_t'(down_ctrl[ect_pkg::DC_EDGE_LSB +: 2]);

  // bus: one wait state, ack drops in the cycle after it is given
  assign wr_req      = cyc_i & stb_i & we_i & ~ack_o;
  assign wr_val      = {(sel_i[1] ? dat_i[15:8] : 8'h00), (sel_i[0] ? dat_i[7:0] : 8'h00)};
  assign quad_cnt_wr = wr_req & (adr_i == ect_pkg::ADR_QUAD_CNT) & (|sel_i[1:0]);
  assign down_cnt_wr = wr_req & (adr_i == ect_pkg::ADR_DOWN_CNT) & (|sel_i[1:0]);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_o <= 1'b0;
    else
      ack_o <= cyc_i & stb_i & ~ack_o;
  end

  // unmapped addresses ack with zero data and ignore writes
  always_comb
  begin
    next_dat = 32'h0000_0000;
    unique case (adr_i)
      ect_pkg::ADR_QUAD_CNT:  next_dat[W-1:0] = quad_cnt; // RULE_01
      ect_pkg::ADR_QUAD_CTRL: next_dat[ect_pkg::QC_W-1:0] = quad_ctrl;
      ect_pkg::ADR_DOWN_CNT:  next_dat[W-1:0] = down_cnt; // RULE_12
      ect_pkg::ADR_DOWN_CTRL: next_dat[ect_pkg::DC_W-1:0] = down_ctrl;
      ect_pkg::ADR_QUAD_RELD: next_dat[W-1:0] = quad_reld;
      ect_pkg::ADR_DOWN_RELD: next_dat[W-1:0] = down_reld;
      default:                next_dat = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_o <= 32'h0000_0000;
    else if (cyc_i & stb_i & ~we_i & ~ack_o)
      dat_o <= next_dat;
  end

  // mode bits are plain software state; setting them before start is up to software
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      quad_ctrl <= ect_pkg::RST_QCTRL;
    else if (wr_req & (adr_i == ect_pkg::ADR_QUAD_CTRL) & sel_i[0])
      quad_ctrl <= dat_i[ect_pkg::QC_W-1:0]; // RULE_19
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      down_ctrl <= ect_pkg::RST_DCTRL;
    else if (wr_req & (adr_i == ect_pkg::ADR_DOWN_CTRL) & sel_i[0])
      down_ctrl <= dat_i[ect_pkg::DC_W-1:0];
  end

  // quadrature decode; in x4 mode a simultaneous up and down cancel
  always_comb
  begin
    if (quad_x4)
    begin
      q_up = (edg.a_rise & edg.b_lvl) | (edg.a_fall & ~edg.b_lvl)
           | (edg.b_rise & ~edg.a_lvl) | (edg.b_fall & edg.a_lvl); // RULE_05
      q_dn = (edg.a_fall & edg.b_lvl) | (edg.a_rise & ~edg.b_lvl)
           | (edg.b_rise & edg.a_lvl) | (edg.b_fall & ~edg.a_lvl); // RULE_06
    end
    else
    begin
      q_up = edg.a_rise & edg.b_lvl; // RULE_04
      q_dn = edg.a_fall & edg.b_lvl; // RULE_04
    end
  end

  assign q_ovf = quad_run & q_up & ~q_dn & (quad_cnt == ect_pkg::CNT_MAX);
  assign q_unf = quad_run & q_dn & ~q_up & (quad_cnt == ect_pkg::CNT_ZERO);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      quad_reld <= ect_pkg::RST_CNT;
    else if (quad_cnt_wr)
      quad_reld <= wr_val; // RULE_02 RULE_03
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      quad_cnt <= ect_pkg::RST_CNT;
    else if (quad_cnt_wr & ~quad_run)
      quad_cnt <= wr_val; // RULE_02
    else if ((q_ovf | q_unf) & ~count_type_select)
      quad_cnt <= quad_reld; // RULE_15 RULE_17 RULE_03
    else if (quad_run & q_up & ~q_dn)
      quad_cnt <= quad_cnt + ect_pkg::CNT_ONE; // RULE_17
    else if (quad_run & q_dn & ~q_up)
      quad_cnt <= quad_cnt - ect_pkg::CNT_ONE;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      quad_irq_o <= 1'b0;
    else
      quad_irq_o <= q_ovf | q_unf; // RULE_16
  end

  // down-only event counter
  always_comb
  begin
    unique case (down_edge)
      ect_pkg::ECT_EDGE_FALL: d_evt = edg.d_fall; // RULE_07
      ect_pkg::ECT_EDGE_RISE: d_evt = edg.d_rise;
      ect_pkg::ECT_EDGE_BOTH: d_evt = edg.d_rise | edg.d_fall;
      default:                d_evt = 1'b0;
    endcase
  end

  assign d_unf = down_run & d_evt & (down_cnt == ect_pkg::CNT_ZERO); // RULE_09

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      down_reld <= ect_pkg::RST_CNT;
    else if (down_cnt_wr)
      down_reld <= wr_val; // RULE_13 RULE_14
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      down_cnt <= ect_pkg::RST_CNT;
    else if (down_cnt_wr & ~down_run)
      down_cnt <= wr_val; // RULE_13
    else if (d_unf)
      down_cnt <= down_reld; // RULE_08 RULE_14
    else if (down_run & d_evt)
      down_cnt <= down_cnt - ect_pkg::CNT_ONE; // RULE_08 RULE_10
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      down_irq_o <= 1'b0;
    else
      down_irq_o <= d_unf; // RULE_11
  end

  a_quad_read_count: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_01
    (cyc_i & stb_i & ~we_i & ~ack_o & adr_i == ect_pkg::ADR_QUAD_CNT)
    |=> (dat_o[W-1:0] == $past(quad_cnt)))
    else $error("quad count read mismatch");
  a_read_high_zero: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_18
    (cyc_i & stb_i & ~we_i & ~ack_o & (adr_i == ect_pkg::ADR_QUAD_CNT | adr_i == ect_pkg::ADR_DOWN_CNT))
    |=> ((dat_o >> W) == 32'h0000_0000))
    else $error("count read shows bits above the counter width");
  a_quad_stop_load: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_02
    (quad_cnt_wr & ~quad_run)
    |=> (quad_cnt == $past(wr_val)) && (quad_reld == $past(wr_val)))
    else $error("stopped quad write must load both");
  a_quad_run_write: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_03
    (quad_cnt_wr & quad_run & ~q_up & ~q_dn)
    |=> (quad_cnt == $past(quad_cnt)) && (quad_reld == $past(wr_val)))
    else $error("running quad write must load reload only");
  a_quad_halted: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_16
    (~quad_run & ~quad_cnt_wr)
    |=> (quad_cnt == $past(quad_cnt)) && ~quad_irq_o)
    else $error("stopped quad counter moved");
  a_quad_norm_up: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_04
    (quad_run & ~quad_x4 & edg.a_rise & edg.b_lvl & ~quad_cnt_wr & quad_cnt != ect_pkg::CNT_MAX)
    |=> (quad_cnt == $past(quad_cnt) + ect_pkg::CNT_ONE))
    else $error("normal mode up count missed");
  a_quad_norm_down: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_04
    (quad_run & ~quad_x4 & edg.a_fall & edg.b_lvl & ~quad_cnt_wr & quad_cnt != ect_pkg::CNT_ZERO)
    |=> (quad_cnt == $past(quad_cnt) - ect_pkg::CNT_ONE))
    else $error("normal mode down count missed");
  a_quad_norm_idle: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_04
    (quad_run & ~quad_x4 & ~edg.b_lvl & ~quad_cnt_wr)
    |=> (quad_cnt == $past(quad_cnt)) && ~quad_irq_o)
    else $error("normal mode counted with secondary low");
  a_quad_x4_up: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_05
    (quad_run & quad_x4 & edg.a_rise & edg.b_lvl & ~edg.b_rise & ~edg.b_fall & ~quad_cnt_wr
     & quad_cnt != ect_pkg::CNT_MAX)
    |=> (quad_cnt == $past(quad_cnt) + ect_pkg::CNT_ONE))
    else $error("x4 mode up count missed");
  a_quad_x4_down: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_06
    (quad_run & quad_x4 & edg.a_fall & edg.b_lvl & ~edg.b_rise & ~edg.b_fall & ~quad_cnt_wr
     & quad_cnt != ect_pkg::CNT_ZERO)
    |=> (quad_cnt == $past(quad_cnt) - ect_pkg::CNT_ONE))
    else $error("x4 mode down count missed");
  a_quad_ovf_reload: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_15
    (q_ovf & ~count_type_select & ~quad_cnt_wr)
    |=> (quad_cnt == $past(quad_reld)) && quad_irq_o)
    else $error("overflow must reload and request");
  a_quad_unf_reload: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_15
    (q_unf & ~count_type_select & ~quad_cnt_wr)
    |=> (quad_cnt == $past(quad_reld)) && quad_irq_o)
    else $error("underflow must reload and request");
  a_quad_free_wrap: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_17
    (q_unf & count_type_select)
    |=> (quad_cnt == ect_pkg::CNT_MAX) && quad_irq_o)
    else $error("free run underflow must wrap");
  a_quad_free_ovf: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_17
    (q_ovf & count_type_select)
    |=> (quad_cnt == ect_pkg::CNT_ZERO) && quad_irq_o)
    else $error("free run overflow must wrap");
  a_down_underflow: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_11
    (d_unf & ~down_cnt_wr)
    |=> (down_cnt == $past(down_reld)) && down_irq_o)
    else $error("underflow must reload and request");
  a_down_no_early: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_09
    (down_run & d_evt & down_cnt != ect_pkg::CNT_ZERO)
    |=> ~down_irq_o)
    else $error("down request before the last counted event");
  a_down_halted: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_10
    (~down_run & ~down_cnt_wr)
    |=> (down_cnt == $past(down_cnt)) && ~down_irq_o)
    else $error("stopped down counter moved");
  a_down_stop_load: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_13
    (down_cnt_wr & ~down_run)
    |=> (down_cnt == $past(wr_val)) && (down_reld == $past(wr_val)))
    else $error("stopped down write must load both");
  a_down_run_write: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_14
    (down_cnt_wr & down_run & ~d_evt)
    |=> (down_cnt == $past(down_cnt)) && (down_reld == $past(wr_val)))
    else $error("running down write must load reload only");
  a_down_read_count: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_12
    (cyc_i & stb_i & ~we_i & ~ack_o & adr_i == ect_pkg::ADR_DOWN_CNT)
    |=> (dat_o[W-1:0] == $past(down_cnt)))
    else $error("down count read mismatch");
  a_down_edge_sel: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_07
    (down_run & ~down_cnt_wr & down_edge == ect_pkg::ECT_EDGE_RISE & edg.d_fall)
    |=> (down_cnt == $past(down_cnt)))
    else $error("falling edge counted in rising edge mode");
  a_down_only_dec: assert property (@(posedge clk_i) disable iff (rst_i) // RULE_08
    (down_run & d_evt & ~d_unf & ~down_cnt_wr)
    |=> (down_cnt == $past(down_cnt) - ect_pkg::CNT_ONE))
    else $error("down counter must decrement by one");
endmodule

// File: bench/ect_pulse_src.sv
// behavioural pin source: quadrature encoder plus a single event line
// assumes the bench calls its tasks just after a rising edge of clk_i
`timescale 1ns/100ps
module ect_pulse_src
(
  input  wire logic clk_i,
  output logic      quad_a_o,
  output logic      quad_b_o,
  output logic      event_o
);
  initial
  begin
    quad_a_o = 1'b0;
    quad_b_o = 1'b0;
    event_o  = 1'b0;
  end

  // six cycles a level: above the two the synchroniser needs, plus its latency
  task automatic settle();
    repeat (6) @(posedge clk_i);
  endtask

  task automatic set_ab(input logic a, input logic b);
    quad_a_o <= a;
    quad_b_o <= b;
    settle();
  endtask

  // one gray quarter step, only one phase moves
  task automatic quad_step(input logic up);
    if ((quad_a_o == quad_b_o) == up)
      quad_b_o <= ~quad_b_o;
    else
      quad_a_o <= ~quad_a_o;
    settle();
  endtask

  task automatic ev_pulse();
    event_o <= 1'b1;
    settle();
    event_o <= 1'b0;
    settle();
  endtask
endmodule

// File: bench/tb_top.sv
// self-checking bench for the event counter timers
// assumes the pulse source model drives the three counter pins
`timescale 1ns/100ps
module tb_top;
  logic        clk_i;
  logic        rst_i;
  logic        cyc_i;
  logic        stb_i;
  logic        we_i;
  logic [7:0]  adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        quad_a;
  logic        quad_b;
  logic        ev_pin;
  logic        quad_irq_o;
  logic        down_irq_o;
  logic [31:0] q;
  int          errors;
  int          num_checks;
  int          qn;
  int          dn;
  int          dec [4];

  ect_timers dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .quad_primary_input_i(quad_a), .quad_secondary_input_i(quad_b),
    .down_event_input_i(ev_pin), .quad_irq_o(quad_irq_o), .down_irq_o(down_irq_o));
  ect_pulse_src src (.clk_i(clk_i), .quad_a_o(quad_a), .quad_b_o(quad_b), .event_o(ev_pin));

  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // irq outputs are one-cycle pulses, so count them at every edge
  always @(posedge clk_i)
  begin
    if (quad_irq_o === 1'b1)
      qn++;
    if (down_irq_o === 1'b1)
      dn++;
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1 && n < 20);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (ack_o !== 1'b1)
    begin
      errors++;
      $display("unexpected at %0t: no bus answer", $time);
      end_of_test();
    end
    else
      @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask

  initial
  begin
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i  = 1'b0;
    adr_i = 8'h00;
    sel_i = 4'h0;
    dat_i = 32'h0;
    dec   = '{1, 1, 2, 0};
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 7; i++)
      rc(8'(i * 4), 32'h0);
    $display("reset values done");
    for (int e = 0; e < 4; e++)
    begin
      wr(ect_pkg::ADR_DOWN_CTRL, 32'h0);
      wr(ect_pkg::ADR_DOWN_CNT, 32'h000a);
      wr(ect_pkg::ADR_DOWN_CTRL, {29'h0, e[1:0], 1'b1});
      src.ev_pulse();
      rc(ect_pkg::ADR_DOWN_CNT, 32'(10 - dec[e]));
    end
    wr(ect_pkg::ADR_DOWN_CTRL, 32'h2);
    src.ev_pulse();
    rc(ect_pkg::ADR_DOWN_CNT, 32'h000a);
    $display("edge select done");
    wr(ect_pkg::ADR_DOWN_CNT, 32'h1234_0003);
    rc(ect_pkg::ADR_DOWN_RELD, 32'h0003);
    wr(ect_pkg::ADR_DOWN_CTRL, 32'h3);
    repeat (4) src.ev_pulse();
    chk(dn, 1);
    rc(ect_pkg::ADR_DOWN_CNT, 32'h0003);
    repeat (2) src.ev_pulse();
    wr(ect_pkg::ADR_DOWN_CNT, 32'h0005);
    rc(ect_pkg::ADR_DOWN_CNT, 32'h0001);
    rc(ect_pkg::ADR_DOWN_RELD, 32'h0005);
    repeat (2) src.ev_pulse();
    rc(ect_pkg::ADR_DOWN_CNT, 32'h0005);
    chk(dn, 2);
    $display("down counter done");
    src.set_ab(1'b0, 1'b1);
    wr(ect_pkg::ADR_QUAD_CNT, 32'hfffe);
    rc(ect_pkg::ADR_QUAD_RELD, 32'hfffe);
    wr(ect_pkg::ADR_QUAD_CTRL, 32'h1);
    src.set_ab(1'b1, 1'b1);
    rc(ect_pkg::ADR_QUAD_CNT, 32'hffff);
    src.set_ab(1'b0, 1'b1);
    rc(ect_pkg::ADR_QUAD_CNT, 32'hfffe);
    src.set_ab(1'b1, 1'b1);
    src.set_ab(1'b1, 1'b0);
    src.set_ab(1'b0, 1'b0);
    src.set_ab(1'b0, 1'b1);
    src.set_ab(1'b1, 1'b1);
    rc(ect_pkg::ADR_QUAD_CNT, 32'hfffe);
    chk(qn, 1);
    wr(ect_pkg::ADR_QUAD_CNT, 32'h0001);
    rc(ect_pkg::ADR_QUAD_CNT, 32'hfffe);
    rc(ect_pkg::ADR_QUAD_RELD, 32'h0001);
    $display("quad normal done");
    wr(ect_pkg::ADR_QUAD_CTRL, 32'h2);
    wr(ect_pkg::ADR_QUAD_CNT, 32'h0001);
    wr(ect_pkg::ADR_QUAD_CTRL, 32'h3);
    repeat (4) src.quad_step(1'b1);
    rc(ect_pkg::ADR_QUAD_CNT, 32'h0005);
    repeat (6) src.quad_step(1'b0);
    rc(ect_pkg::ADR_QUAD_CNT, 32'h0001);
    chk(qn, 2);
    wr(ect_pkg::ADR_QUAD_CTRL, 32'h6);
    wr(ect_pkg::ADR_QUAD_CTRL, 32'h7);
    repeat (2) src.quad_step(1'b0);
    rc(ect_pkg::ADR_QUAD_CNT, 32'hffff);
    chk(qn, 3);
    src.quad_step(1'b1);
    rc(ect_pkg::ADR_QUAD_CNT, 32'h0000);
    chk(qn, 4);
    $display("quad x4 and free run done");
    end_of_test();
  end
endmodule
